// ---- inc/rtcal_map.svh ----
// Offsets, field positions, reset values and timing counts of the alarm block
`ifndef RTCAL_MAP_SVH
`define RTCAL_MAP_SVH
`define RTCAL_OFF_WDHR 6'h00
`define RTCAL_OFF_MINSEC 6'h01
`define RTCAL_OFF_CFG 6'h02
`define RTCAL_OFF_CAL 6'h03
`define RTCAL_OFF_MD 6'h04
`define RTCAL_WDAY_LSB 8
`define RTCAL_HRT_LSB 4
`define RTCAL_MINT_LSB 12
`define RTCAL_MINO_LSB 8
`define RTCAL_SECT_LSB 4
`define RTCAL_EN_BIT 15
`define RTCAL_ENDLESS_BIT 14
`define RTCAL_MASK_LSB 10
`define RTCAL_TON_BIT 15
`define RTCAL_WREN_BIT 13
`define RTCAL_SYNC_BIT 12
`define RTCAL_WDHR_RMASK 16'h073f
`define RTCAL_MINSEC_RMASK 16'h7f7f
`define RTCAL_MD_RMASK 16'h1f3f
`define RTCAL_RST16 16'h0000
`define RTCAL_RST8 8'h00
`define RTCAL_RST4 4'h0
`define RTCAL_RPT_WRAP 8'hff
`define RTCAL_MASK_HALF 4'h0
`define RTCAL_MASK_SEC 4'h1
`define RTCAL_MASK_10SEC 4'h2
`define RTCAL_MASK_MIN 4'h3
`define RTCAL_MASK_10MIN 4'h4
`define RTCAL_MASK_HOUR 4'h5
`define RTCAL_MASK_DAY 4'h6
`define RTCAL_MASK_WEEK 4'h7
`define RTCAL_MASK_MONTH 4'h8
`define RTCAL_MASK_YEAR 4'h9
`define RTCAL_REF_HZ 200000000
`define RTCAL_OSC_HZ 32768
`define RTCAL_OSC_DIV (`RTCAL_REF_HZ / `RTCAL_OSC_HZ)
`define RTCAL_HALF_PULSES 17'sh04000
`define RTCAL_HALVES_PER_MIN 7'h77
`define RTCAL_SYNC_WINDOW 17'sh00020
`define RTCAL_RESP_OK 2'h0
`define RTCAL_RESP_SLVERR 2'h2
`endif

// ---- inc/rtcal_pkg.sv ----
// Shared types of the alarm and calibration block
package rtcal_pkg;
  typedef logic [3:0] rtcal_mask_t;
  typedef logic [7:0] rtcal_byte_t;
  typedef logic [15:0] rtcal_half_t;
  typedef logic signed [16:0] rtcal_phase_t;
endpackage

// ---- hw/rtcal_prescale.sv ----
// Oscillator divider, half-second prescaler and once-a-minute calibration
`timescale 1ns/1ps
`include "rtcal_map.svh"
module rtcal_prescale #(
  parameter logic [15:0] OSC_DIV = 16'(`RTCAL_OSC_DIV),
  parameter rtcal_pkg::rtcal_phase_t HALF_PULSES = `RTCAL_HALF_PULSES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire rtcal_pkg::rtcal_byte_t cal,
  output logic half_tick,
  output logic sec_tick,
  output logic near_sec
);
  logic [15:0] div_q, div_d;
  rtcal_pkg::rtcal_phase_t cnt_q, cnt_d;
  logic [6:0] halves_q, halves_d;
  logic half_q, half_d, sec_q, sec_d, near_q, near_d, adj_q, adj_d;
  logic osc_en;

  assign half_tick = half_q;
  assign sec_tick = sec_q;
  assign near_sec = near_q;

  always_comb
  begin
    osc_en = (div_q == OSC_DIV - 16'h0001);
    div_d = osc_en ? 16'h0000 : div_q + 16'h0001;
    cnt_d = cnt_q;
    halves_d = halves_q;
    half_d = 1'b0;
    sec_d = 1'b0;
    adj_d = 1'b0;
    if (!run)
    begin
      div_d = 16'h0000;
    end
    else if (osc_en)
    begin
      cnt_d = cnt_q + 17'sh00001;
      if (cnt_q >= HALF_PULSES - 17'sh00001)
      begin
        half_d = 1'b1;
        sec_d = halves_q[0];
        cnt_d = 17'sh00000;
        halves_d = halves_q + 7'h01;
        if (halves_q == `RTCAL_HALVES_PER_MIN)
        begin
          // Signed offset times four; negative lengthens the minute
          cnt_d = {{7{cal[7]}}, cal, 2'b00};
          halves_d = 7'h00;
          adj_d = 1'b1;
        end
      end
    end
    near_d = run && halves_q[0] && (cnt_q >= HALF_PULSES - `RTCAL_SYNC_WINDOW);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 16'h0000;
      cnt_q <= 17'sh00000;
      halves_q <= 7'h00;
      half_q <= 1'b0;
      sec_q <= 1'b0;
      near_q <= 1'b0;
      adj_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      halves_q <= halves_d;
      half_q <= half_d;
      sec_q <= sec_d;
      near_q <= near_d;
      adj_q <= adj_d;
    end
  end

  cal_apply_a: assert property (@(posedge clk) disable iff (rst)
    adj_q |-> cnt_q == {{7{$past(cal[7])}}, $past(cal), 2'b00})
    else $error("calibration offset not loaded");
endmodule

// ---- hw/rtcal_match.sv ----
// Alarm digit comparison under the interval mask
`timescale 1ns/1ps
`include "rtcal_map.svh"
module rtcal_match (
  input wire rtcal_pkg::rtcal_mask_t mask,
  input wire rtcal_pkg::rtcal_half_t al_wdhr,
  input wire rtcal_pkg::rtcal_half_t al_minsec,
  input wire rtcal_pkg::rtcal_half_t al_md,
  input wire rtcal_pkg::rtcal_half_t now_wdhr,
  input wire rtcal_pkg::rtcal_half_t now_minsec,
  input wire rtcal_pkg::rtcal_half_t now_md,
  output logic match
);
  function automatic logic same(input logic [15:0] a, input logic [15:0] b,
                                input logic [15:0] m);
    same = ((a ^ b) & m) == 16'h0000;
  endfunction

  // Each wider mask adds digits to the narrower one, except month, which drops the weekday digit of the week mask
  always_comb
  begin
    match = 1'b0;
    case (mask)
      `RTCAL_MASK_SEC: match = 1'b1;
      `RTCAL_MASK_10SEC: match = same(al_minsec, now_minsec, 16'h000f);
      `RTCAL_MASK_MIN: match = same(al_minsec, now_minsec, 16'h007f);
      `RTCAL_MASK_10MIN: match = same(al_minsec, now_minsec, 16'h0f7f);
      `RTCAL_MASK_HOUR: match = same(al_minsec, now_minsec, 16'h7f7f);
      `RTCAL_MASK_DAY: match = same(al_minsec, now_minsec, 16'h7f7f)
        && same(al_wdhr, now_wdhr, 16'h003f);
      `RTCAL_MASK_WEEK: match = same(al_minsec, now_minsec, 16'h7f7f)
        && same(al_wdhr, now_wdhr, 16'h073f);
      `RTCAL_MASK_MONTH: match = same(al_minsec, now_minsec, 16'h7f7f)
        && same(al_wdhr, now_wdhr, 16'h003f) && same(al_md, now_md, 16'h003f);
      // Feb 29 only exists in leap years, so that date fires every fourth year
      `RTCAL_MASK_YEAR: match = same(al_minsec, now_minsec, 16'h7f7f)
        && same(al_wdhr, now_wdhr, 16'h003f) && same(al_md, now_md, 16'h1f3f);
      default: match = 1'b0;
    endcase
  end
endmodule

// ---- hw/rtcal_top.sv ----
// Alarm and calibration block with an AXI4-Lite register slave
// Contract
// - weekday digit in bits 10:8, reserved zero
// - hour BCD tens 5:4, ones 3:0
// - weekday/hours writes need clock write enable
// - minute BCD tens 14:12, ones 11:8
// - second BCD tens 6:4, ones 3:0
// - minute adjust by four times calibration
// - negative calibration adds pulses each minute
// - final alarm clears alarm enable
// - mask field 13:10 picks interval
// - yearly Feb 29 fires every fourth year
// - zero repeat, no endless: one alarm
// - repeat counter decrements per alarm
// - at zero: last alarm, then disable
// - endless repeat wraps counter to FFh
// - interrupt at every alarm event
// - alarm pulse toggles each alarm event
// - enable bit 15, endless bit 14
`timescale 1ns/1ps
`include "rtcal_map.svh"
module rtcal_top #(
  parameter logic [15:0] OSC_DIV = 16'(`RTCAL_OSC_DIV),
  parameter rtcal_pkg::rtcal_phase_t HALF_PULSES = `RTCAL_HALF_PULSES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [15:0] NOW_WDAY_HOURS,
  input wire logic [15:0] NOW_MIN_SEC,
  input wire logic [15:0] NOW_MONTH_DAY,
  output logic IRQ,
  output logic ALARM_PULSE
);
  logic aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d, r_v_q, r_v_d;
  logic aw_rdy_q, aw_rdy_d, w_rdy_q, w_rdy_d, ar_rdy_q, ar_rdy_d;
  logic [5:0] aw_a_q, aw_a_d;
  logic [15:0] w_d_q, w_d_d;
  logic [1:0] w_s_q, w_s_d, b_r_q, b_r_d, r_r_q, r_r_d;
  logic [31:0] r_d_q, r_d_d;
  rtcal_pkg::rtcal_half_t wdhr_q, wdhr_d, minsec_q, minsec_d, md_q, md_d;
  logic en_q, en_d, endless_q, endless_d, ton_q, ton_d, wren_q, wren_d;
  rtcal_pkg::rtcal_mask_t mask_q, mask_d;
  rtcal_pkg::rtcal_byte_t rpt_q, rpt_d, cal_q, cal_d;
  logic irq_q, irq_d, pulse_q, pulse_d;
  logic wr_go, half_tick, sec_tick, near_sec, match, fire;
  logic [15:0] wv, cfg_rd, cal_rd;

  function automatic logic mapped(input logic [5:0] idx);
    mapped = idx <= `RTCAL_OFF_MD;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] dat,
                                        input logic [1:0] strb);
    merge = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
  endfunction

  rtcal_prescale #(
    .OSC_DIV(OSC_DIV),
    .HALF_PULSES(HALF_PULSES)
  ) u_prescale (
    .clk(REF_CLK),
    .rst(RESET),
    .run(ton_q),
    .cal(cal_q),
    .half_tick(half_tick),
    .sec_tick(sec_tick),
    .near_sec(near_sec)
  );

  rtcal_match u_match (
    .mask(mask_q),
    .al_wdhr(wdhr_q),
    .al_minsec(minsec_q),
    .al_md(md_q),
    .now_wdhr(NOW_WDAY_HOURS),
    .now_minsec(NOW_MIN_SEC),
    .now_md(NOW_MONTH_DAY),
    .match(match)
  );

  assign S_AXI_AWREADY = aw_rdy_q;
  assign S_AXI_WREADY = w_rdy_q;
  assign S_AXI_BVALID = b_v_q;
  assign S_AXI_BRESP = b_r_q;
  assign S_AXI_ARREADY = ar_rdy_q;
  assign S_AXI_RVALID = r_v_q;
  assign S_AXI_RDATA = r_d_q;
  assign S_AXI_RRESP = r_r_q;
  assign IRQ = irq_q;
  assign ALARM_PULSE = pulse_q;

  assign cfg_rd = {en_q, endless_q, mask_q, 2'b00, rpt_q};
  assign cal_rd = {ton_q, 1'b0, wren_q, near_sec, 4'h0, cal_q};
  assign wr_go = aw_v_q && w_v_q && !b_v_q;
  // Half-second mode fires on every half tick; others only on whole seconds
  assign fire = en_q && ((mask_q == `RTCAL_MASK_HALF) ? half_tick
    : (sec_tick && match));

  // Bus handshake and read path
  always_comb
  begin
    aw_v_d = aw_v_q;
    aw_a_d = aw_a_q;
    w_v_d = w_v_q;
    w_d_d = w_d_q;
    w_s_d = w_s_q;
    b_v_d = b_v_q;
    b_r_d = b_r_q;
    r_v_d = r_v_q;
    r_d_d = r_d_q;
    r_r_d = r_r_q;
    if (S_AXI_AWVALID && aw_rdy_q)
    begin
      aw_v_d = 1'b1;
      aw_a_d = S_AXI_AWADDR[7:2];
    end
    if (S_AXI_WVALID && w_rdy_q)
    begin
      w_v_d = 1'b1;
      w_d_d = S_AXI_WDATA[15:0];
      w_s_d = S_AXI_WSTRB[1:0];
    end
    if (b_v_q && S_AXI_BREADY)
    begin
      b_v_d = 1'b0;
    end
    if (wr_go)
    begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      b_v_d = 1'b1;
      b_r_d = mapped(aw_a_q) ? `RTCAL_RESP_OK : `RTCAL_RESP_SLVERR;
    end
    if (r_v_q && S_AXI_RREADY)
    begin
      r_v_d = 1'b0;
    end
    if (S_AXI_ARVALID && ar_rdy_q)
    begin
      r_v_d = 1'b1;
      r_r_d = mapped(S_AXI_ARADDR[7:2]) ? `RTCAL_RESP_OK : `RTCAL_RESP_SLVERR;
      case (S_AXI_ARADDR[7:2])
        `RTCAL_OFF_WDHR: r_d_d = {16'h0000, wdhr_q & `RTCAL_WDHR_RMASK};
        `RTCAL_OFF_MINSEC: r_d_d = {16'h0000, minsec_q & `RTCAL_MINSEC_RMASK};
        `RTCAL_OFF_CFG: r_d_d = {16'h0000, cfg_rd};
        `RTCAL_OFF_CAL: r_d_d = {16'h0000, cal_rd};
        `RTCAL_OFF_MD: r_d_d = {16'h0000, md_q & `RTCAL_MD_RMASK};
        default: r_d_d = 32'h00000000;
      endcase
    end
    aw_rdy_d = !aw_v_d && !b_v_d;
    w_rdy_d = !w_v_d && !b_v_d;
    ar_rdy_d = !r_v_d;
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      aw_v_q <= 1'b0;
      aw_a_q <= 6'h00;
      w_v_q <= 1'b0;
      w_d_q <= `RTCAL_RST16;
      w_s_q <= 2'h0;
      b_v_q <= 1'b0;
      b_r_q <= `RTCAL_RESP_OK;
      r_v_q <= 1'b0;
      r_d_q <= 32'h00000000;
      r_r_q <= `RTCAL_RESP_OK;
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      ar_rdy_q <= 1'b0;
    end
    else
    begin
      aw_v_q <= aw_v_d;
      aw_a_q <= aw_a_d;
      w_v_q <= w_v_d;
      w_d_q <= w_d_d;
      w_s_q <= w_s_d;
      b_v_q <= b_v_d;
      b_r_q <= b_r_d;
      r_v_q <= r_v_d;
      r_d_q <= r_d_d;
      r_r_q <= r_r_d;
      aw_rdy_q <= aw_rdy_d;
      w_rdy_q <= w_rdy_d;
      ar_rdy_q <= ar_rdy_d;
    end
  end

  // Register writes and the alarm sequencer
  always_comb
  begin
    wdhr_d = wdhr_q;
    minsec_d = minsec_q;
    md_d = md_q;
    en_d = en_q;
    endless_d = endless_q;
    mask_d = mask_q;
    rpt_d = rpt_q;
    cal_d = cal_q;
    ton_d = ton_q;
    wren_d = wren_q;
    irq_d = 1'b0;
    pulse_d = pulse_q;
    wv = 16'h0000;
    if (wr_go)
    begin
      case (aw_a_q)
        `RTCAL_OFF_WDHR:
        begin
          if (wren_q)
          begin
            wdhr_d = merge(wdhr_q, w_d_q, w_s_q) & `RTCAL_WDHR_RMASK;
          end
        end
        `RTCAL_OFF_MINSEC: minsec_d = merge(minsec_q, w_d_q, w_s_q) & `RTCAL_MINSEC_RMASK;
        `RTCAL_OFF_CFG:
        begin
          wv = merge(cfg_rd, w_d_q, w_s_q);
          en_d = wv[`RTCAL_EN_BIT];
          endless_d = wv[`RTCAL_ENDLESS_BIT];
          mask_d = wv[`RTCAL_MASK_LSB +: 4];
          rpt_d = wv[7:0];
        end
        `RTCAL_OFF_CAL:
        begin
          wv = merge(cal_rd, w_d_q, w_s_q);
          ton_d = wv[`RTCAL_TON_BIT];
          wren_d = wv[`RTCAL_WREN_BIT];
          cal_d = wv[7:0];
        end
        `RTCAL_OFF_MD:
        begin
          if (wren_q)
          begin
            md_d = merge(md_q, w_d_q, w_s_q) & `RTCAL_MD_RMASK;
          end
        end
        default: wv = 16'h0000;
      endcase
    end
    // Hardware sequencing outranks a same-cycle software write
    if (fire)
    begin
      irq_d = 1'b1;
      pulse_d = !pulse_q;
      en_d = en_q;
      if (rpt_q != `RTCAL_RST8)
      begin
        rpt_d = rpt_q - 8'h01;
      end
      else if (endless_q)
      begin
        rpt_d = `RTCAL_RPT_WRAP;
      end
      else
      begin
        rpt_d = rpt_q;
        en_d = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wdhr_q <= `RTCAL_RST16;
      minsec_q <= `RTCAL_RST16;
      md_q <= `RTCAL_RST16;
      en_q <= 1'b0;
      endless_q <= 1'b0;
      mask_q <= `RTCAL_RST4;
      rpt_q <= `RTCAL_RST8;
      cal_q <= `RTCAL_RST8;
      ton_q <= 1'b0;
      wren_q <= 1'b0;
      irq_q <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      wdhr_q <= wdhr_d;
      minsec_q <= minsec_d;
      md_q <= md_d;
      en_q <= en_d;
      endless_q <= endless_d;
      mask_q <= mask_d;
      rpt_q <= rpt_d;
      cal_q <= cal_d;
      ton_q <= ton_d;
      wren_q <= wren_d;
      irq_q <= irq_d;
      pulse_q <= pulse_d;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence last_evt_s;
    fire && rpt_q == `RTCAL_RST8 && !endless_q;
  endsequence

  sequence wrap_evt_s;
    fire && rpt_q == `RTCAL_RST8 && endless_q;
  endsequence

  wdhr_read_a: assert property (
    S_AXI_ARVALID && ar_rdy_q && S_AXI_ARADDR[7:2] == `RTCAL_OFF_WDHR
    |=> S_AXI_RVALID && S_AXI_RDATA[31:11] == 21'h0 && S_AXI_RDATA[7:6] == 2'h0)
    else $error("weekday register reserved bits not zero");
  wdhr_guard_a: assert property (
    wr_go && aw_a_q == `RTCAL_OFF_WDHR && !wren_q |=> $stable(wdhr_q))
    else $error("weekday register written while locked");
  minsec_read_a: assert property (
    S_AXI_ARVALID && ar_rdy_q && S_AXI_ARADDR[7:2] == `RTCAL_OFF_MINSEC
    |=> S_AXI_RDATA[15] == 1'b0 && S_AXI_RDATA[7] == 1'b0)
    else $error("minute register reserved bits not zero");
  repeat_dec_a: assert property (
    fire && rpt_q != `RTCAL_RST8 |=> rpt_q == $past(rpt_q) - 8'h01 && en_q)
    else $error("repeat count did not step down");
  final_off_a: assert property (last_evt_s |=> !en_q ##1 !IRQ)
    else $error("alarm still enabled after final event");
  endless_wrap_a: assert property (wrap_evt_s |=> rpt_q == 8'hff && en_q)
    else $error("endless repeat did not wrap");
  irq_event_a: assert property (fire |=> IRQ ##1 (!IRQ || $past(fire)))
    else $error("interrupt missing after alarm");
  pulse_toggle_a: assert property (fire |=> ALARM_PULSE != $past(ALARM_PULSE))
    else $error("alarm pulse did not toggle");
  half_mode_a: assert property (
    en_q && mask_q == `RTCAL_MASK_HALF && half_tick
    |=> IRQ && ALARM_PULSE != $past(ALARM_PULSE))
    else $error("half-second alarm missed");
  bus_resp_a: assert property (wr_go |=> S_AXI_BVALID [*1] ##0 !S_AXI_AWREADY)
    else $error("write response not raised");
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the alarm and calibration block
`timescale 1ns/1ps
module tb_top;
  localparam int HALF = 256;
  localparam int LIM = HALF + 300;
  localparam int WATCHDOG_NS = 450000;
  int cyc = 0;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] now_wdhr = 16'h0000;
  logic [15:0] now_minsec = 16'h0000;
  logic [15:0] now_md = 16'h0000;
  wire awready, wready, bvalid, arready, rvalid, irq, alarm_pulse;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int miscompares = 0;
  int num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    cyc <= cyc + 1;

  // Short divider and half second keep a whole minute near 30720 cycles
  rtcal_top #(.OSC_DIV(16'h0001), .HALF_PULSES(17'sh00100)) rtcal_top_i (
    .REF_CLK(ref_clk), .RESET(reset),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .NOW_WDAY_HOURS(now_wdhr), .NOW_MIN_SEC(now_minsec), .NOW_MONTH_DAY(now_md),
    .IRQ(irq), .ALARM_PULSE(alarm_pulse)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is looked at on the falling edge, so it is the value the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw_p;
    logic w_p;
    logic aw_hs;
    logic w_hs;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p)
    begin
      @(negedge ref_clk);
      aw_hs = aw_p && awready;
      w_hs = w_p && wready;
      @(posedge ref_clk);
      if (aw_hs)
      begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_hs)
      begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do
    begin
      @(negedge ref_clk);
    end
    while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] msk, input logic [15:0] exp,
                    input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge ref_clk);
    end
    while (!arready);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do
    begin
      @(negedge ref_clk);
    end
    while (!rvalid);
    chk(rdata & {16'h0000, msk}, {16'h0000, exp});
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask

  // Watches for one alarm event; a fired event must be a one-cycle pulse with a toggle
  task automatic irq_win(input int lim, input logic fire);
    logic p0;
    logic seen;
    int n;
    p0 = alarm_pulse;
    seen = 1'b0;
    n = 0;
    while (!seen && n < lim)
    begin
      @(negedge ref_clk);
      seen = irq;
      n++;
    end
    chk({31'h0, seen}, {31'h0, fire});
    if (fire)
    begin
      chk({31'h0, alarm_pulse}, {31'h0, ~p0});
      @(negedge ref_clk);
      chk({31'h0, irq}, 32'h00000000);
    end
  endtask

  task automatic t_regs;
    for (int i = 0; i < 5; i++)
    begin
      rd(8'(i * 4), 16'hefff, 16'h0000, 2'h0);
    end
    wr(8'h00, 16'h0615, 2'h0);
    rd(8'h00, 16'hffff, 16'h0000, 2'h0);
    wr(8'h0c, 16'h20fc, 2'h0);
    rd(8'h0c, 16'hefff, 16'h20fc, 2'h0);
    wr(8'h0c, 16'h2000, 2'h0);
    wr(8'h00, 16'hffff, 2'h0);
    rd(8'h00, 16'hffff, 16'h073f, 2'h0);
    wr(8'h04, 16'hffff, 2'h0);
    rd(8'h04, 16'hffff, 16'h7f7f, 2'h0);
    wr(8'h14, 16'h1234, 2'h2);
    rd(8'h14, 16'hffff, 16'h0000, 2'h2);
    rd(8'hfc, 16'hffff, 16'h0000, 2'h2);
    wr(8'h0c, 16'ha000, 2'h0);
  endtask

  task automatic t_single;
    wr(8'h08, 16'h8000, 2'h0);
    irq_win(LIM, 1'b1);
    rd(8'h08, 16'hffff, 16'h0000, 2'h0);
    irq_win(LIM, 1'b0);
  endtask

  task automatic t_repeat;
    wr(8'h08, 16'h8001, 2'h0);
    irq_win(LIM, 1'b1);
    rd(8'h08, 16'hffff, 16'h8000, 2'h0);
    irq_win(LIM, 1'b1);
    rd(8'h08, 16'hffff, 16'h0000, 2'h0);
  endtask

  task automatic t_endless;
    wr(8'h08, 16'hc000, 2'h0);
    irq_win(LIM, 1'b1);
    rd(8'h08, 16'hffff, 16'hc0ff, 2'h0);
    wr(8'h08, 16'h0000, 2'h0);
  endtask

  // Seconds-ones mask: tens digit differs on purpose, only the ones digit may decide
  task automatic t_mask;
    wr(8'h04, 16'h5937, 2'h0);
    @(posedge ref_clk);
    now_minsec <= 16'h0008;
    wr(8'h08, 16'h8800, 2'h0);
    irq_win(2 * LIM, 1'b0);
    rd(8'h08, 16'hffff, 16'h8800, 2'h0);
    @(posedge ref_clk);
    now_minsec <= 16'h0017;
    irq_win(2 * LIM, 1'b1);
    rd(8'h08, 16'hffff, 16'h0800, 2'h0);
  endtask

  // Calibration only written with the timer stopped; one of any 120 halves carries the offset
  task automatic t_cal(input logic [7:0] c);
    int prev;
    int odd;
    int odd_len;
    prev = 0;
    odd = 0;
    odd_len = 0;
    wr(8'h0c, 16'h2000, 2'h0);
    wr(8'h0c, {8'h20, c}, 2'h0);
    wr(8'h0c, {8'ha0, c}, 2'h0);
    wr(8'h08, 16'hc000, 2'h0);
    for (int i = 0; i <= 120; i++)
    begin
      irq_win(LIM, 1'b1);
      if (i > 0 && cyc - prev != HALF)
      begin
        odd++;
        odd_len = cyc - prev;
      end
      prev = cyc;
    end
    chk(32'(odd), 32'h00000001);
    chk(32'(odd_len), 32'(HALF - 4 * int'($signed(c))));
    rd(8'h0c, 16'h1000, 16'h0000, 2'h0);
    wr(8'h08, 16'h0000, 2'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(WATCHDOG_NS);
    miscompares++;
    $display("[ERR] %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_regs();
    t_single();
    t_repeat();
    t_endless();
    t_mask();
    t_cal(8'hfc);
    t_cal(8'h10);
    tally_and_finish();
  end
endmodule
